// ### hw/pra_program_rom_addressing.sv
// Functional notes
// - word 0000h is the reset vector; fetch starts there after any reset.
// - cause flags: power-on 1/0, watchdog 0/0, external 1/1 (timeout/powerdown).
// - any reset loads all registers with defaults and restarts at 0000h.
// - interrupt service saves pc in the stack buffer, then jumps to 0008h.
// - push/pop save accumulator and flags, minus cause flags, one level only.
// - table read address: high index bits 0-1 give address bits 8-9, low index bits 0-7.
// - table read puts word low byte in accumulator, high byte in result register.
// - low index wrap never bumps the high index.
// - pc low byte plus accumulator carry increments the upper pc bits.
// - pc low byte minus accumulator borrow leaves upper pc bits alone.
// - each rom word is 16 bits, returned as two bytes.
module pra_program_rom_addressing (
	input wire logic hclk, // bus and core clock
	input wire logic hresetn, // power-on reset, async low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic ext_rst_pin_n, // external reset pin
	input wire logic wdt_overflow, // watchdog overflow level
	input wire logic [15:0] rom_data, // rom word, one cycle after rd
	output pra_pkg::pra_rom_req_type rom_req, // rom address and table read
	output logic [7:0] flag_out // program_flag_register image
);
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic ph_wr;
	logic ph_rd;
	logic [7:0] ph_addr;
	logic next_ph_wr;
	logic next_ph_rd;
	logic [7:0] next_ph_addr;
	logic [31:0] next_hrdata;
	logic [9:0] pc;
	logic [7:0] acc;
	logic [7:0] program_flag_register;
	logic [7:0] idx_high;
	logic [7:0] idx_low;
	logic [7:0] table_result;
	pra_pkg::pra_ctx_type ctx;
	logic ctx_valid;
	logic [9:0] ret_pc;
	logic ret_valid;
	pra_pkg::pra_state_type state;
	pra_pkg::pra_rom_req_type next_rom_req;
	logic [9:0] next_pc;
	logic [7:0] next_acc;
	logic [7:0] next_flag;
	logic [7:0] next_idx_high;
	logic [7:0] next_idx_low;
	logic [7:0] next_table_result;
	pra_pkg::pra_ctx_type next_ctx;
	logic next_ctx_valid;
	logic [9:0] next_ret_pc;
	logic next_ret_valid;
	pra_pkg::pra_state_type next_state;
	pra_pkg::pra_cmd_type cmd;
	logic [8:0] low_sum;
	logic ext_req;
	logic wdt_req;
	logic busy;

	// pins come from outside the clock domain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 2'b01;
			sync2 <= 2'b01;
		end else begin
			sync1 <= {wdt_overflow, ext_rst_pin_n};
			sync2 <= sync1;
		end
	end

	assign ext_req = ~sync2[0];
	assign wdt_req = sync2[1];
	assign busy = (state != pra_pkg::ST_IDLE);

	// bus address phase and read data
	always_comb begin
		next_ph_wr = 1'b0;
		next_ph_rd = 1'b0;
		next_ph_addr = ph_addr;
		next_hrdata = hrdata;
		if (hsel && hready && htrans[1]) begin
			next_ph_wr = hwrite;
			next_ph_rd = ~hwrite;
			next_ph_addr = haddr[7:0];
			next_hrdata = pra_pkg::HRDATA_RST;
			if (!hwrite) begin
				case (haddr[7:0])
					pra_pkg::OFF_PC: next_hrdata = {22'h0, pc};
					pra_pkg::OFF_ACC: next_hrdata = {24'h0, acc};
					pra_pkg::OFF_FLAG: next_hrdata = {24'h0, program_flag_register};
					pra_pkg::OFF_IDXH: next_hrdata = {24'h0, idx_high};
					pra_pkg::OFF_IDXL: next_hrdata = {24'h0, idx_low};
					pra_pkg::OFF_TRES: next_hrdata = {24'h0, table_result};
					pra_pkg::OFF_STAT: next_hrdata = {29'h0, ctx_valid, ret_valid, busy};
					pra_pkg::OFF_CTX: next_hrdata = {16'h0, ctx};
					pra_pkg::OFF_RET: next_hrdata = {22'h0, ret_pc};
					default: next_hrdata = pra_pkg::HRDATA_RST;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_addr <= 8'h00;
			hrdata <= pra_pkg::HRDATA_RST;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ph_wr <= next_ph_wr;
			ph_rd <= next_ph_rd;
			ph_addr <= next_ph_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// core state
	always_comb begin
		next_pc = pc;
		next_acc = acc;
		next_flag = program_flag_register;
		next_idx_high = idx_high;
		next_idx_low = idx_low;
		next_table_result = table_result;
		next_ctx = ctx;
		next_ctx_valid = ctx_valid;
		next_ret_pc = ret_pc;
		next_ret_valid = ret_valid;
		next_state = state;
		next_rom_req = rom_req;
		next_rom_req.rd = 1'b0;
		cmd = pra_pkg::CMD_NONE;
		low_sum = 9'h000;
		if (ph_wr) begin
			case (ph_addr)
				pra_pkg::OFF_CMD: cmd = pra_pkg::pra_cmd_type'(hwdata[3:0]);
				pra_pkg::OFF_PC: next_pc = hwdata[9:0];
				pra_pkg::OFF_ACC: next_acc = hwdata[7:0];
				// cause flags are read-only to software
				pra_pkg::OFF_FLAG: next_flag = (hwdata[7:0] & ~pra_pkg::FLAG_CAUSE_MASK)
					| (program_flag_register & pra_pkg::FLAG_CAUSE_MASK);
				pra_pkg::OFF_IDXH: next_idx_high = hwdata[7:0];
				pra_pkg::OFF_IDXL: next_idx_low = hwdata[7:0];
				pra_pkg::OFF_TRES: next_table_result = hwdata[7:0];
				default: cmd = pra_pkg::CMD_NONE;
			endcase
		end
		// commands are dropped while a table read is in flight
		if (state == pra_pkg::ST_IDLE) begin
			case (cmd)
				pra_pkg::CMD_STEP: next_pc = pc + 10'h001;
				pra_pkg::CMD_IRQ: begin
					next_ret_pc = pc;
					next_ret_valid = 1'b1;
					next_pc = pra_pkg::IRQ_VEC;
				end
				pra_pkg::CMD_RETURN_FROM_INTERRUPT: begin
					if (ret_valid) begin
						next_pc = ret_pc;
						next_ret_valid = 1'b0;
					end
				end
				pra_pkg::CMD_PUSH: begin
					// single slot: a second push overwrites the first
					next_ctx.acc = acc;
					next_ctx.flag = program_flag_register & ~pra_pkg::FLAG_CAUSE_MASK;
					next_ctx_valid = 1'b1;
				end
				pra_pkg::CMD_POP: begin
					next_acc = ctx.acc;
					next_flag = ctx.flag | (program_flag_register & pra_pkg::FLAG_CAUSE_MASK);
				end
				pra_pkg::CMD_TBL: begin
					// rom is ten bits wide, upper index bits fall off the top
					next_rom_req.addr = {idx_high[1:0], idx_low};
					next_rom_req.rd = 1'b1;
					next_state = pra_pkg::ST_FETCH;
				end
				pra_pkg::CMD_JADD: begin
					low_sum = {1'b0, pc[7:0]} + {1'b0, acc};
					next_pc[7:0] = low_sum[7:0];
					next_pc[9:8] = pc[9:8] + {1'b0, low_sum[8]};
				end
				pra_pkg::CMD_JSUB: begin
					low_sum = {1'b0, pc[7:0]} - {1'b0, acc};
					next_pc[7:0] = low_sum[7:0];
					next_pc[9:8] = pc[9:8];
				end
				default: next_state = pra_pkg::ST_IDLE;
			endcase
		end
		case (state)
			pra_pkg::ST_IDLE: begin
				if (next_state == pra_pkg::ST_IDLE) begin
					next_rom_req.addr = next_pc;
				end
			end
			pra_pkg::ST_FETCH: next_state = pra_pkg::ST_CAPTURE;
			pra_pkg::ST_CAPTURE: begin
				next_acc = rom_data[7:0];
				next_table_result = rom_data[15:8];
				next_rom_req.addr = next_pc;
				next_state = pra_pkg::ST_IDLE;
			end
			default: next_state = pra_pkg::ST_IDLE;
		endcase
		// a held reset request keeps everything at defaults
		if (ext_req || wdt_req) begin
			next_pc = pra_pkg::RESET_VEC;
			next_acc = pra_pkg::ACC_RST;
			next_idx_high = pra_pkg::IDX_RST;
			next_idx_low = pra_pkg::IDX_RST;
			next_table_result = pra_pkg::TRES_RST;
			next_ctx = '0;
			next_ctx_valid = 1'b0;
			next_ret_pc = pra_pkg::RESET_VEC;
			next_ret_valid = 1'b0;
			next_state = pra_pkg::ST_IDLE;
			next_rom_req.rd = 1'b0;
			next_rom_req.addr = pra_pkg::RESET_VEC;
			// external wins if both are seen together
			next_flag = ext_req ? pra_pkg::FLAG_EXT : pra_pkg::FLAG_WDT;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= pra_pkg::RESET_VEC;
			acc <= pra_pkg::ACC_RST;
			program_flag_register <= pra_pkg::FLAG_POR;
			idx_high <= pra_pkg::IDX_RST;
			idx_low <= pra_pkg::IDX_RST;
			table_result <= pra_pkg::TRES_RST;
			ctx <= '0;
			ctx_valid <= 1'b0;
			ret_pc <= pra_pkg::RESET_VEC;
			ret_valid <= 1'b0;
			state <= pra_pkg::ST_IDLE;
			rom_req <= '0;
			flag_out <= pra_pkg::FLAG_POR;
		end else begin
			pc <= next_pc;
			acc <= next_acc;
			program_flag_register <= next_flag;
			idx_high <= next_idx_high;
			idx_low <= next_idx_low;
			table_result <= next_table_result;
			ctx <= next_ctx;
			ctx_valid <= next_ctx_valid;
			ret_pc <= next_ret_pc;
			ret_valid <= next_ret_valid;
			state <= next_state;
			rom_req <= next_rom_req;
			flag_out <= next_flag;
		end
	end
endmodule

// ### shared/pra_pkg.sv
package pra_pkg;
	localparam int PC_W = 10;
	localparam logic [9:0] RESET_VEC = 10'h000;
	localparam logic [9:0] IRQ_VEC = 10'h008;
	localparam logic [9:0] PC_LAST = 10'h3ff;
	localparam logic [9:0] USER_END = 10'h3fc;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_PC = 8'h04;
	localparam logic [7:0] OFF_ACC = 8'h08;
	localparam logic [7:0] OFF_FLAG = 8'h0c;
	localparam logic [7:0] OFF_IDXH = 8'h10;
	localparam logic [7:0] OFF_IDXL = 8'h14;
	localparam logic [7:0] OFF_TRES = 8'h18;
	localparam logic [7:0] OFF_STAT = 8'h1c;
	localparam logic [7:0] OFF_CTX = 8'h20;
	localparam logic [7:0] OFF_RET = 8'h24;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_PD = 6;
	localparam int FLAG_TO = 7;
	localparam logic [7:0] FLAG_CAUSE_MASK = 8'hc0;
	localparam logic [7:0] FLAG_POR = 8'h80;
	localparam logic [7:0] FLAG_WDT = 8'h00;
	localparam logic [7:0] FLAG_EXT = 8'hc0;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] IDX_RST = 8'h00;
	localparam logic [7:0] TRES_RST = 8'h00;
	localparam int STAT_BUSY = 0;
	localparam int STAT_RET_VALID = 1;
	localparam int STAT_CTX_VALID = 2;
	localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_STEP = 4'h1,
		CMD_IRQ = 4'h2,
		CMD_RETURN_FROM_INTERRUPT = 4'h3,
		CMD_PUSH = 4'h4,
		CMD_POP = 4'h5,
		CMD_TBL = 4'h6,
		CMD_JADD = 4'h7,
		CMD_JSUB = 4'h8
	} pra_cmd_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_CAPTURE = 2'b10
	} pra_state_type;
	typedef struct packed {
		logic rd;
		logic [9:0] addr;
	} pra_rom_req_type;
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] flag;
	} pra_ctx_type;
endpackage

// ### verification/pra_rom_model.sv
module pra_rom_model (
	input wire logic hclk, // core clock
	input wire pra_pkg::pra_rom_req_type rom_req, // fetch request
	output logic [15:0] rom_data // word, one cycle after rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial rom_data = 16'h0000;
	// word is 6'h15 over the address; off-cycle data toggles so a late sample fails
	always @(posedge hclk) begin
		rom_data <= rom_req.rd ? {6'h15, rom_req.addr} : ~rom_data;
	end
endmodule

// ### verification/pra_program_rom_addressing_assertions.sv
module pra_program_rom_addressing_assertions (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, low
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer
	input wire logic hwrite, // write
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // ready
	input wire logic ext_rst_pin_n, // ext reset
	input wire logic wdt_overflow, // watchdog
	input wire pra_pkg::pra_rom_req_type rom_req, // rom request
	input wire logic [7:0] flag_out // flags
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cmd_ph, rd_q, next_cmd_ph, next_rd_q, go;
	always_comb begin
		next_cmd_ph = hsel && hready && htrans[1] && hwrite && haddr[7:0] == pra_pkg::OFF_CMD;
		next_rd_q = rom_req.rd;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_ph <= 1'b0;
			rd_q <= 1'b0;
		end else begin
			cmd_ph <= next_cmd_ph;
			rd_q <= next_rd_q;
		end
	end
	// commands are dropped while a table read is in flight
	assign go = cmd_ph && !rom_req.rd && !rd_q && ext_rst_pin_n && !wdt_overflow;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	rd_pulse_a: assert property (rom_req.rd |=> !rom_req.rd)
		else $error("rom strobe too long");
	tbl_start_a: assert property (go && hwdata[3:0] == pra_pkg::CMD_TBL |=> rom_req.rd)
		else $error("table read not started");
	irq_vec_a: assert property (go && hwdata[3:0] == pra_pkg::CMD_IRQ |=> rom_req.addr == pra_pkg::IRQ_VEC)
		else $error("irq vector wrong");
	step_wrap_a: assert property (go && hwdata[3:0] == pra_pkg::CMD_STEP |=>
		rom_req.addr == $past(rom_req.addr) + 10'h001) else $error("step wrong");
	ext_cause_a: assert property ((!ext_rst_pin_n)[*4] |-> flag_out == pra_pkg::FLAG_EXT)
		else $error("external cause flags wrong");
	wdt_cause_a: assert property ((ext_rst_pin_n && wdt_overflow)[*4] |-> flag_out == pra_pkg::FLAG_WDT)
		else $error("watchdog cause flags wrong");
	rst_vec_a: assert property ((!ext_rst_pin_n || wdt_overflow)[*4] |->
		rom_req.addr == pra_pkg::RESET_VEC && !rom_req.rd) else $error("reset vector wrong");
	cause_keep_a: assert property ($changed(flag_out[7:6]) |->
		!$past(ext_rst_pin_n, 3) || $past(wdt_overflow, 3)) else $error("cause flags moved");
endmodule

bind pra_program_rom_addressing pra_program_rom_addressing_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.ext_rst_pin_n(ext_rst_pin_n), .wdt_overflow(wdt_overflow), .rom_req(rom_req), .flag_out(flag_out));

// ### verification/test_program_rom_addressing.sv
module test_program_rom_addressing;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, ext_rst_pin_n, wdt_overflow, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [15:0] rom_data;
	logic [7:0] flag_out;
	pra_pkg::pra_rom_req_type rom_req;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	pra_program_rom_addressing DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_rst_pin_n(ext_rst_pin_n),
		.wdt_overflow(wdt_overflow), .rom_data(rom_data), .rom_req(rom_req), .flag_out(flag_out));
	pra_rom_model u_rom (.hclk(hclk), .rom_req(rom_req), .rom_data(rom_data));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		// one idle edge so a following read sees the write
		if (w) @(posedge hclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		n_checks++;
		if (q !== e) begin
			$display("FAIL t=%0t got %h exp %h", $time, q, e);
			num_errors++;
		end
		// the slave never signals an error response
		n_checks++;
		if (hresp !== 1'b0) begin
			$display("FAIL t=%0t hresp got %h exp %h", $time, hresp, 1'b0);
			num_errors++;
		end
	endtask
	task automatic cmd(input pra_pkg::pra_cmd_type c);
		bus(1'b1, pra_pkg::OFF_CMD, {28'h0, c});
	endtask
	task automatic t_por;
		rc(pra_pkg::OFF_FLAG, 32'h80);
		rc(pra_pkg::OFF_PC, 32'h0);
	endtask
	task automatic t_table;
		logic [15:0] w;
		w = {6'h15, 2'b10, 8'hff};
		bus(1'b1, pra_pkg::OFF_IDXH, 32'h6);
		bus(1'b1, pra_pkg::OFF_IDXL, 32'hff);
		cmd(pra_pkg::CMD_TBL);
		repeat (3) @(posedge hclk);
		rc(pra_pkg::OFF_ACC, {24'h0, w[7:0]});
		rc(pra_pkg::OFF_TRES, {24'h0, w[15:8]});
		bus(1'b1, pra_pkg::OFF_IDXL, 32'h0);
		rc(pra_pkg::OFF_IDXH, 32'h6);
	endtask
	task automatic t_jump;
		bus(1'b1, pra_pkg::OFF_PC, 32'h0fd);
		bus(1'b1, pra_pkg::OFF_ACC, 32'h5);
		cmd(pra_pkg::CMD_JADD);
		rc(pra_pkg::OFF_PC, 32'h102);
		cmd(pra_pkg::CMD_JSUB);
		rc(pra_pkg::OFF_PC, 32'h1fd);
		bus(1'b1, pra_pkg::OFF_PC, 32'h3ff);
		cmd(pra_pkg::CMD_STEP);
		rc(pra_pkg::OFF_PC, 32'h0);
	endtask
	task automatic t_irq;
		bus(1'b1, pra_pkg::OFF_PC, 32'h123);
		cmd(pra_pkg::CMD_IRQ);
		rc(pra_pkg::OFF_PC, 32'h8);
		rc(pra_pkg::OFF_RET, 32'h123);
		cmd(pra_pkg::CMD_RETURN_FROM_INTERRUPT);
		rc(pra_pkg::OFF_PC, 32'h123);
	endtask
	task automatic t_ctx;
		bus(1'b1, pra_pkg::OFF_ACC, 32'h3c);
		bus(1'b1, pra_pkg::OFF_FLAG, 32'hff);
		cmd(pra_pkg::CMD_PUSH);
		rc(pra_pkg::OFF_CTX, 32'h3c3f);
		rc(pra_pkg::OFF_STAT, 32'h4);
		bus(1'b1, pra_pkg::OFF_ACC, 32'h0);
		bus(1'b1, pra_pkg::OFF_FLAG, 32'h0);
		cmd(pra_pkg::CMD_POP);
		rc(pra_pkg::OFF_ACC, 32'h3c);
		rc(pra_pkg::OFF_FLAG, 32'hbf);
	endtask
	task automatic t_resets;
		ext_rst_pin_n <= 1'b0;
		repeat (5) @(posedge hclk);
		ext_rst_pin_n <= 1'b1;
		rc(pra_pkg::OFF_FLAG, 32'hc0);
		rc(pra_pkg::OFF_ACC, 32'h0);
		rc(pra_pkg::OFF_PC, 32'h0);
		wdt_overflow <= 1'b1;
		repeat (5) @(posedge hclk);
		wdt_overflow <= 1'b0;
		rc(pra_pkg::OFF_FLAG, 32'h0);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			test_done();
		end
	end
	initial begin
		{hresetn, hsel, hwrite, wdt_overflow, htrans, haddr, hwdata} = '0;
		ext_rst_pin_n = 1'b1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_por();
		t_table();
		t_jump();
		t_irq();
		t_ctx();
		t_resets();
		test_done();
	end
endmodule
